/* File: hw/pwm_fault_router.sv */
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
// -------------------------------------------------------------
// Overview of operation
// (R1) detect at once, count once per cycle
// (R2) each fault module has own limit
// (R3) flag when consecutive count exceeds limit
// (R4) flag held until channel enable drops
// (R5) enable low clears all engine flags together
// (R6) one global fault enable per engine
// (R7) cycle-limit, both, A and B modules
// (R8) four identical modules, different output wiring
// (R9) one cycle-by-cycle block per engine
// (R10) cycle-by-cycle block ends pulse on trip
// (R11) many sources into one module
// (R12) one source into many engines
// (R13) any event combination per fault input
// (R14) digital comparators on error converter samples
// (R15) analog comparator thresholds and fault config
// (R16) external fault pins with programmable polarity
// (R17) pwm current, voltage, A, B, diode faults
// (R18) oscillator failure as fault source
// (R19) discontinuous conduction detection as event
// (R20) count clears on clean cycle or disable
// -------------------------------------------------------------
module fault_module
  import fault_router_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             detect,
  input  wire logic             cycle_start,
  input  wire logic             ch_en,
  input  wire logic             glob_en,
  input  wire logic [CNT_W-1:0] max_count,
  output logic                  fault_now,
  output logic                  flag
);
  typedef struct packed {
    logic           seen;
    logic [CNT_W:0] cnt;
    logic           flag;
  } fm_st_t;

  fm_st_t s;
  fm_st_t next_s;
  logic   en;

  assign en        = ch_en & glob_en;               // see (R6)
  assign fault_now = en & detect;                   // see (R1)
  assign flag      = s.flag;

  always_comb begin
    next_s = s;
    if (cycle_start) begin
      next_s.seen = 1'b0;
      if (!s.seen) next_s.cnt = '0;                 // see (R20)
    end
    if (fault_now && (!s.seen || cycle_start)) begin // see (R1)
      next_s.seen = 1'b1;
      if (next_s.cnt <= {1'b0, max_count}) begin
        next_s.cnt = next_s.cnt + 1'b1;
      end
    end
    if (next_s.cnt > {1'b0, max_count}) next_s.flag = 1'b1; // see (R3)
    if (!en) begin
      next_s.seen = 1'b0;
      next_s.cnt  = '0;                             // see (R20)
    end
    if (!ch_en) next_s.flag = 1'b0;                 // see (R4)
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) s <= '0;
    else        s <= next_s;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  flag_clear_a: assert property (!ch_en |=> !flag) // see (R4)
    else $error("flag survived channel disable");
  flag_hold_a: assert property (flag && ch_en |=> flag) // see (R4)
    else $error("flag dropped while channel enabled");
  once_per_cycle_a: assert property ( // see (R1)
    s.seen && !cycle_start && en |=> s.cnt == $past(s.cnt))
    else $error("second fault counted in one cycle");
  limit_flag_a: assert property ( // see (R3)
    s.cnt > {1'b0, max_count} |-> s.flag)
    else $error("count over limit without flag");
  count_clear_a: assert property (!en |=> s.cnt == '0) // see (R20)
    else $error("count kept while disabled");
endmodule

module pwm_fault_router
  import fault_router_pkg::*;
#(
  parameter int CLK_FAIL_CYCLES = 1000
)(
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  input  wire fault_router_pkg::av_req_t   av,
  output logic [31:0]                      av_readdata,
  output logic                             av_waitrequest,
  input  wire logic [NDC-1:0][ERR_W-1:0]   err_sample,
  input  wire logic [NAC-1:0]              acomp_raw,
  output logic [NAC-1:0][ACT_W-1:0]        acomp_threshold,
  input  wire logic [NEXT-1:0]             ext_fault_pin,
  input  wire logic                        hf_osc_tick,
  input  wire logic                        lf_osc_tick,
  input  wire logic [NENG-1:0]             current_zero,
  input  wire fault_router_pkg::pwm_flt_t [NENG-1:0] pwm_fault,
  input  wire logic [NENG-1:0]             pcm_trip,
  input  wire logic [NENG-1:0]             cycle_start,
  input  wire logic [NENG-1:0]             pwm_channel_enable,
  output logic [NENG-1:0]                  shut_a,
  output logic [NENG-1:0]                  shut_b,
  output logic [NENG-1:0]                  pulse_end_a,
  output logic [NENG-1:0]                  pulse_end_b,
  output logic [NENG-1:0][NMOD-1:0]        fault_flag
);
  import fault_router_pkg::*;

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    logic [NENG*NMOD-1:0][RT_W-1:0] route;
    logic [NDC-1:0][DC_W-1:0]       dc;
    logic [NAC-1:0][AC_W-1:0]       ac;
    logic [EXT_W-1:0]               ext;
    logic [NENG-1:0][ENG_W-1:0]     eng;
    logic                           ack;
    logic [31:0]                    rdata;
    logic [NENG-1:0]                zseen;
    logic [NENG-1:0]                dcm;
    logic [NENG-1:0]                cbc_lat;
    logic [CF_W-1:0]                hf_cnt;
    logic [CF_W-1:0]                lf_cnt;
  } top_st_t;

  localparam logic [CF_W-1:0] CF_LIM = CF_W'(CLK_FAIL_CYCLES);

  top_st_t                     s;
  top_st_t                     next_s;
  logic [NDC-1:0]              dc_ev;
  logic [NAC-1:0]              ac_ev;
  logic [NEXT-1:0]             ext_ev;
  logic                        hf_fail;
  logic                        lf_fail;
  logic [NENG-1:0][NEV-1:0]    ev;
  logic [NENG-1:0][NMOD-1:0]   now;
  logic [31:0]                 bm;
  logic [31:0]                 rd;
  logic [ADR_W-1:0]            off;
  logic                        req;

  // -------------------------------------------------------------
  // fault sources
  // -------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NDC; i++) begin             // see (R14)
      dc_ev[i] = s.dc[i][DC_EN_BIT] & (s.dc[i][DC_GT_BIT]
        ? $signed(err_sample[i]) > $signed(s.dc[i][ERR_W-1:0])
        : $signed(err_sample[i]) < $signed(s.dc[i][ERR_W-1:0]));
    end
    for (int i = 0; i < NAC; i++) begin             // see (R15)
      ac_ev[i] = s.ac[i][AC_EN_BIT] & (acomp_raw[i] ^ s.ac[i][AC_INV_BIT]);
      acomp_threshold[i] = s.ac[i][ACT_W-1:0];
    end
    // pin polarity bit set means the pin faults when low
    ext_ev = s.ext[NEXT-1:0]                        // see (R16)
           & (ext_fault_pin ^ s.ext[EXT_POL +: NEXT]);
  end

  // missing ticks are only seen after the full timeout
  assign hf_fail = s.hf_cnt == CF_LIM;              // see (R18)
  assign lf_fail = s.lf_cnt == CF_LIM;

  // -------------------------------------------------------------
  // engines
  // -------------------------------------------------------------
  genvar e, m;
  generate
    for (e = 0; e < NENG; e++) begin : g_eng
      // every engine sees the same shared sources      see (R12)
      assign ev[e] = {pcm_trip[e],
                      pwm_fault[e] & s.eng[e][ENG_PWM_W-1:0], // see (R17)
                      s.dcm[e], lf_fail, hf_fail,
                      ext_ev, ac_ev, dc_ev};
      for (m = 0; m < NMOD; m++) begin : g_mod
        fault_module u_fm (                         // see (R8)
          .clk_sys     (clk_sys),
          .rst_n       (rst_n),
          // masked or of any events               see (R11) (R13)
          .detect      (|(ev[e] & s.route[e*NMOD+m][NEV-1:0])),
          .cycle_start (cycle_start[e]),
          .ch_en       (pwm_channel_enable[e]),     // see (R5)
          .glob_en     (s.eng[e][ENG_GEN]),         // see (R6)
          .max_count   (s.route[e*NMOD+m][RT_MAX_LSB +: CNT_W]), // see (R2)
          .fault_now   (now[e][m]),
          .flag        (fault_flag[e][m])
        );
      end
      assign shut_a[e] = fault_flag[e][M_CL] | fault_flag[e][M_AB]
                       | fault_flag[e][M_A] | now[e][M_AB]
                       | now[e][M_A];               // see (R7)
      assign shut_b[e] = fault_flag[e][M_CL] | fault_flag[e][M_AB]
                       | fault_flag[e][M_B] | now[e][M_AB]
                       | now[e][M_B];               // see (R7)
      // single cycle-by-cycle block, fed by the cycle-limit module
      assign pulse_end_a[e] = s.eng[e][ENG_CBC]
                            & (now[e][M_CL] | s.cbc_lat[e]); // see (R10)
      assign pulse_end_b[e] = pulse_end_a[e] & s.eng[e][ENG_BFOL]; // see (R9)

      ab_shut_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fault_flag[e][M_AB] |-> shut_a[e] && shut_b[e]) // see (R7)
        else $error("both-output flag did not shut both outputs");
      glob_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !s.eng[e][ENG_GEN] |-> now[e] == '0)        // see (R6)
        else $error("fault passed with global enable low");
      cbc_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pulse_end_a[e] && !cycle_start[e] ##1 s.eng[e][ENG_CBC]
        |-> pulse_end_a[e])                         // see (R10)
        else $error("pulse termination released mid cycle");
      dcm_take_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cycle_start[e] |=> s.dcm[e] ==
          $past(s.zseen[e] | current_zero[e]))      // see (R19)
        else $error("conduction mode not taken at cycle start");
    end
  endgenerate

  // -------------------------------------------------------------
  // bus and state update
  // -------------------------------------------------------------
  assign req            = av.read | av.write;
  assign av_waitrequest = req & ~s.ack;
  assign av_readdata    = s.rdata;

  always_comb begin
    next_s = s;
    for (int i = 0; i < 4; i++) bm[8*i +: 8] = {8{av.byteenable[i]}};
    rd  = RST_WORD;
    off = av.address;
    // one wait state, so data is ready at the accepting edge
    next_s.ack = req & ~s.ack;
    if (av.address < DC_IDX) begin
      off = av.address - RT_IDX;
      rd  = 32'(s.route[off[3:0]]);
      if (av.write && s.ack) begin
        next_s.route[off[3:0]] = RT_W'((rd & ~bm) | (av.writedata & bm));
      end
    end else if (av.address < AC_IDX) begin
      off = av.address - DC_IDX;
      rd  = 32'(s.dc[off[1:0]]);
      if (av.write && s.ack) begin
        next_s.dc[off[1:0]] = DC_W'((rd & ~bm) | (av.writedata & bm));
      end
    end else if (av.address < EXT_IDX) begin
      off = av.address - AC_IDX;
      rd  = 32'(s.ac[off[2:0]]);
      if (av.write && s.ack) begin
        next_s.ac[off[2:0]] = AC_W'((rd & ~bm) | (av.writedata & bm));
      end
    end else if (av.address < ENG_IDX) begin
      rd = 32'(s.ext);
      if (av.write && s.ack) begin
        next_s.ext = EXT_W'((rd & ~bm) | (av.writedata & bm));
      end
    end else if (av.address < STAT_IDX) begin
      off = av.address - ENG_IDX;
      rd  = 32'(s.eng[off[1:0]]);
      if (av.write && s.ack) begin
        next_s.eng[off[1:0]] = ENG_W'((rd & ~bm) | (av.writedata & bm));
      end
    end else if (av.address == STAT_IDX) begin
      rd = RST_WORD;
      rd[NENG*NMOD-1:0]     = fault_flag;
      rd[ST_DCM +: NENG]    = s.dcm;
      rd[ST_HF]             = hf_fail;
      rd[ST_LF]             = lf_fail;
    end
    // unmapped words read zero and ignore writes
    if (req && !s.ack) next_s.rdata = rd;

    for (int i = 0; i < NENG; i++) begin
      if (cycle_start[i]) begin                     // see (R19)
        next_s.dcm[i]   = s.zseen[i] | current_zero[i];
        next_s.zseen[i] = 1'b0;
      end else if (current_zero[i]) begin
        next_s.zseen[i] = 1'b1;
      end
      if (cycle_start[i] || !s.eng[i][ENG_CBC]) next_s.cbc_lat[i] = 1'b0;
      if (now[i][M_CL] && s.eng[i][ENG_CBC]) begin
        next_s.cbc_lat[i] = 1'b1;                   // see (R10)
      end
    end
    next_s.hf_cnt = hf_osc_tick ? '0                // see (R18)
                  : (hf_fail ? s.hf_cnt : s.hf_cnt + 1'b1);
    next_s.lf_cnt = lf_osc_tick ? '0
                  : (lf_fail ? s.lf_cnt : s.lf_cnt + 1'b1);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) s <= '0;
    else        s <= next_s;
  end

  sequence bus_req_s;
    req && av_waitrequest;
  endsequence

  bus_answer_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus_req_s |=> !av_waitrequest)
    else $error("bus request not answered in one wait state");
  osc_fail_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hf_osc_tick |=> !hf_fail)                       // see (R18)
    else $error("oscillator fail with fresh tick");
endmodule

/* File: hw/fault_router_pkg.sv */
package fault_router_pkg;
  // -------------------------------------------------------------
  // sizes
  // -------------------------------------------------------------
  localparam int NENG  = 4;
  localparam int NMOD  = 4;
  localparam int NDC   = 4;
  localparam int NAC   = 7;
  localparam int NEXT  = 4;
  localparam int ERR_W = 10;
  localparam int ACT_W = 7;
  localparam int CNT_W = 4;
  localparam int NEV   = 24;
  localparam int ADR_W = 6;
  localparam int CF_W  = 16;

  // -------------------------------------------------------------
  // fault module positions inside one engine
  // -------------------------------------------------------------
  localparam int M_CL = 0;
  localparam int M_AB = 1;
  localparam int M_A  = 2;
  localparam int M_B  = 3;

  // -------------------------------------------------------------
  // event vector bit positions (per engine)
  // -------------------------------------------------------------
  localparam int EV_DC  = 0;
  localparam int EV_AC  = 4;
  localparam int EV_EXT = 11;
  localparam int EV_HF  = 15;
  localparam int EV_LF  = 16;
  localparam int EV_DCM = 17;
  localparam int EV_PWM = 18;
  localparam int EV_PCM = 23;

  // -------------------------------------------------------------
  // register word indices (byte address is four times these)
  // -------------------------------------------------------------
  localparam logic [ADR_W-1:0] RT_IDX   = 6'h00;
  localparam logic [ADR_W-1:0] DC_IDX   = 6'h10;
  localparam logic [ADR_W-1:0] AC_IDX   = 6'h14;
  localparam logic [ADR_W-1:0] EXT_IDX  = 6'h1b;
  localparam logic [ADR_W-1:0] ENG_IDX  = 6'h1c;
  localparam logic [ADR_W-1:0] STAT_IDX = 6'h20;

  // -------------------------------------------------------------
  // field positions and widths
  // -------------------------------------------------------------
  localparam int RT_W       = 28;
  localparam int RT_MAX_LSB = 24;
  localparam int DC_W       = 18;
  localparam int DC_EN_BIT  = 16;
  localparam int DC_GT_BIT  = 17;
  localparam int AC_W       = 10;
  localparam int AC_EN_BIT  = 8;
  localparam int AC_INV_BIT = 9;
  localparam int EXT_W      = 8;
  localparam int EXT_POL    = 4;
  localparam int ENG_W      = 13;
  localparam int ENG_PWM_W  = 5;
  localparam int ENG_CBC    = 8;
  localparam int ENG_BFOL   = 9;
  localparam int ENG_GEN    = 12;
  localparam int ST_DCM     = 16;
  localparam int ST_HF      = 20;
  localparam int ST_LF      = 21;
  localparam logic [31:0] RST_WORD = 32'h0;

  // -------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------
  typedef struct packed {
    logic diode;
    logic ext_b;
    logic ext_a;
    logic ov;
    logic cl;
  } pwm_flt_t;

  typedef struct packed {
    logic             read;
    logic             write;
    logic [ADR_W-1:0] address;
    logic [3:0]       byteenable;
    logic [31:0]      writedata;
  } av_req_t;
endpackage

/* File: test/pwm_side_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// switching side of the pwm engines and the oscillators
// ----------------------------------------------------------------
module pwm_side_model
  import fault_router_pkg::*;
#(
  parameter int PERIOD = 8
)(
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  input  wire logic                        osc_stop,
  output logic [fault_router_pkg::NENG-1:0] cycle_start,
  output logic                             hf_osc_tick,
  output logic                             lf_osc_tick
);
  int cnt;

  // one shared period so a single source lines up in every engine
  // period stays above 2 so starts never come closer than allowed
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt         <= 0;
      cycle_start <= '0;
      hf_osc_tick <= 1'b0;
      lf_osc_tick <= 1'b0;
    end else begin
      cnt         <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      cycle_start <= {NENG{cnt == PERIOD - 1}};
      // both ticks well inside the fail window: no false clock fault
      // osc_stop silences both oscillators to reach the fail window
      hf_osc_tick <= (cnt[1:0] == 2'h0) & ~osc_stop;
      lf_osc_tick <= cnt[2] & ~osc_stop;
    end
  end
endmodule

/* File: test/tb.sv */
`timescale 1ns/1ps
`define check(name, exp, got) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("unexpected %s exp=%h got=%h", name, exp, got); \
  end \
end
// ----------------------------------------------------------------
// bench for the fault router
// ----------------------------------------------------------------
module tb;
  import fault_router_pkg::*;
  logic                      clk_sys            = 1'b0;
  logic                      rst_n              = 1'b0;
  av_req_t                   av                 = '0;
  logic [NEXT-1:0]           ext_fault_pin      = '0;
  logic [NENG-1:0]           pwm_channel_enable = '0;
  logic [NENG-1:0]           current_zero       = '0;
  logic [NENG-1:0]           pcm_trip           = '0;
  logic [NAC-1:0]            acomp_raw          = '0;
  logic                      osc_stop           = 1'b0;
  logic [NAC-1:0][ACT_W-1:0] acomp_threshold;
  logic [NENG-1:0]           pulse_end_a;
  logic [NENG-1:0]           pulse_end_b;
  logic [31:0]               av_readdata;
  logic                      av_waitrequest;
  logic [NENG-1:0]           cycle_start;
  logic [NENG-1:0]           shut_a;
  logic [NENG-1:0]           shut_b;
  logic [NENG-1:0][NMOD-1:0] fault_flag;
  logic                      hf_osc_tick;
  logic                      lf_osc_tick;
  logic [31:0]               rd;
  int                        n_mismatch         = 0;
  int                        total_checks       = 0;

  always #20 clk_sys = ~clk_sys;

  pwm_side_model #(.PERIOD(8)) side (
    .clk_sys(clk_sys), .rst_n(rst_n), .osc_stop(osc_stop),
    .cycle_start(cycle_start),
    .hf_osc_tick(hf_osc_tick), .lf_osc_tick(lf_osc_tick));

  // short fail window keeps the oscillator path inside a short run
  pwm_fault_router #(.CLK_FAIL_CYCLES(20)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .av(av),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
    .err_sample('0), .acomp_raw(acomp_raw),
    .acomp_threshold(acomp_threshold),
    .ext_fault_pin(ext_fault_pin), .hf_osc_tick(hf_osc_tick),
    .lf_osc_tick(lf_osc_tick), .current_zero(current_zero),
    .pwm_fault('0), .pcm_trip(pcm_trip), .cycle_start(cycle_start),
    .pwm_channel_enable(pwm_channel_enable), .shut_a(shut_a),
    .shut_b(shut_b), .pulse_end_a(pulse_end_a),
    .pulse_end_b(pulse_end_b), .fault_flag(fault_flag));

  // ----------------------------------------------------------------
  // bus and timing helpers
  // ----------------------------------------------------------------
  task automatic bus(input logic is_rd, input logic [ADR_W-1:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    av <= '{is_rd, ~is_rd, a, 4'hf, d};
    // waitrequest is settled mid-cycle; the next rising edge accepts
    do @(negedge clk_sys); while (av_waitrequest !== 1'b0);
    @(posedge clk_sys);
    q = av_readdata;
    av <= '0;
  endtask

  task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
    bus(1'b0, a, d, rd);
  endtask

  task automatic sync_start;
    do @(negedge clk_sys); while (cycle_start[0] !== 1'b1);
  endtask

  // one-clock fault on pin 0 just after a cycle start
  task automatic pulse_pin;
    sync_start;
    @(posedge clk_sys);
    ext_fault_pin <= 4'h1;
    @(posedge clk_sys);
    ext_fault_pin <= 4'h0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    wr(6'h02, 32'h01000800);
    wr(6'h01, 32'h03000800);
    wr(6'h07, 32'h00000800);
    wr(6'h0a, 32'h01000800);
    wr(EXT_IDX, 32'h00000001);
    wr(6'h1c, 32'h00001000);
    wr(6'h1d, 32'h00001000);
    wr(6'h1e, 32'h00000000);
    bus(1'b1, 6'h02, '0, rd);
    `check("route max readback", 32'h01000800, rd)
    wr(6'h30, 32'hffffffff);
    bus(1'b1, 6'h30, '0, rd);
    `check("unmapped read", 32'h0, rd)
    wr(STAT_IDX, 32'hffffffff);
    bus(1'b1, STAT_IDX, '0, rd);
    `check("status after write", 32'h0, rd)
  endtask

  // held fault: one count per cycle, one pin feeds several engines
  task automatic t_count;
    sync_start;
    @(posedge clk_sys);
    ext_fault_pin <= 4'h1;
    @(negedge clk_sys);
    `check("shut a e0", 1'b1, shut_a[0])
    `check("shut b e1", 1'b1, shut_b[1])
    `check("shut a e2 no glob", 1'b0, shut_a[2])
    sync_start;
    `check("flag a before 2nd", 1'b0, fault_flag[0][M_A])
    `check("flag b e1 max0", 1'b1, fault_flag[1][M_B])
    @(negedge clk_sys);
    `check("flag a after 2nd", 1'b1, fault_flag[0][M_A])
    `check("flag ab max3", 1'b0, fault_flag[0][M_AB])
    `check("flag a e2", 1'b0, fault_flag[2][M_A])
    @(posedge clk_sys);
    ext_fault_pin <= 4'h0;
    repeat (10) @(negedge clk_sys);
    `check("flag held", 1'b1, fault_flag[0][M_A])
    bus(1'b1, STAT_IDX, '0, rd);
    `check("status flags", 32'h00000084, rd)
  endtask

  // enable low clears the whole engine, other engines keep theirs
  task automatic t_clear;
    @(posedge clk_sys);
    pwm_channel_enable <= 4'h6;
    @(posedge clk_sys);
    @(negedge clk_sys);
    `check("e0 flags cleared", 4'h0, fault_flag[0])
    `check("e1 flag kept", 1'b1, fault_flag[1][M_B])
    @(posedge clk_sys);
    pwm_channel_enable <= 4'h7;
  endtask

  // a clean cycle between two faulty ones restarts the count
  task automatic t_clean;
    pulse_pin;
    sync_start;
    pulse_pin;
    repeat (3) @(negedge clk_sys);
    `check("flag after clean gap", 1'b0, fault_flag[0][M_A])
    pulse_pin;
    @(negedge clk_sys);
    `check("flag two in a row", 1'b1, fault_flag[0][M_A])
  endtask

  // peak current trip ends the pulse and holds until the next cycle
  task automatic t_cbc;
    wr(RT_IDX, 32'h0f800000);
    wr(ENG_IDX, 32'h00001300);
    sync_start;
    @(posedge clk_sys);
    pcm_trip <= 4'h1;
    @(negedge clk_sys);
    `check("pulse end a", 1'b1, pulse_end_a[0])
    `check("pulse end b follows", 1'b1, pulse_end_b[0])
    `check("no cbc on e1", 1'b0, pulse_end_a[1])
    @(posedge clk_sys);
    pcm_trip <= '0;
    @(negedge clk_sys);
    `check("pulse end latched", 1'b1, pulse_end_a[0])
    sync_start;
    @(negedge clk_sys);
    `check("pulse end released", 1'b0, pulse_end_a[0])
  endtask

  // analog comparator threshold out and its fault into engine 1
  task automatic t_acmp;
    wr(AC_IDX, 32'h00000155);
    wr(6'h06, 32'h0f000010);
    @(negedge clk_sys);
    `check("threshold out", 7'h55, acomp_threshold[0])
    @(posedge clk_sys);
    acomp_raw <= 7'h01;
    @(negedge clk_sys);
    `check("acomp shut a e1", 1'b1, shut_a[1])
    @(posedge clk_sys);
    acomp_raw <= '0;
    @(negedge clk_sys);
    `check("acomp released", 1'b0, shut_a[1])
  endtask

  // zero current in one cycle shows as conduction mode for the next
  task automatic t_dcm;
    sync_start;
    @(posedge clk_sys);
    current_zero <= 4'h2;
    @(posedge clk_sys);
    current_zero <= '0;
    sync_start;
    bus(1'b1, STAT_IDX, '0, rd);
    `check("dcm seen", 4'h2, rd[ST_DCM +: NENG])
    sync_start;
    bus(1'b1, STAT_IDX, '0, rd);
    `check("dcm cleared", 4'h0, rd[ST_DCM +: NENG])
  endtask

  // silent oscillators trip past the short fail window, then recover
  task automatic t_osc;
    @(posedge clk_sys);
    osc_stop <= 1'b1;
    repeat (25) @(posedge clk_sys);
    bus(1'b1, STAT_IDX, '0, rd);
    `check("hf fail", 1'b1, rd[ST_HF])
    `check("lf fail", 1'b1, rd[ST_LF])
    osc_stop <= 1'b0;
    repeat (12) @(posedge clk_sys);
    bus(1'b1, STAT_IDX, '0, rd);
    `check("osc recovered", 2'h0, rd[ST_LF:ST_HF])
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n              <= 1'b1;
    pwm_channel_enable <= 4'h7;
    t_regs;
    t_count;
    t_clear;
    t_clean;
    t_cbc;
    t_acmp;
    t_dcm;
    t_osc;
    close_out;
  end

  // whole run is a few hundred clocks; this leaves ample margin
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_mismatch++;
    close_out;
  end
endmodule
